// *** logic/fph_params.svh ***
// Constants for the flash protection, security-ID and pause controller
`ifndef FPH_PARAMS_SVH
`define FPH_PARAMS_SVH

// ==========================================================
// Timing
`define FPH_CLK_NS 40
`define FPH_WRITE_NS 25000
`define FPH_WRITE_CYC ((`FPH_WRITE_NS + `FPH_CLK_NS - 1) / `FPH_CLK_NS)

// ==========================================================
// Command opcodes
`define FPH_OPC_WRITE_ENABLE_CMD 8'h16
`define FPH_OPC_WRDI 8'h14
`define FPH_OPC_WRITE_STATUS_CMD 8'h11
`define FPH_OPC_RDSR 8'h15
`define FPH_OPC_LOCKDOWN_PROTECT_CMD 8'h8e
`define FPH_OPC_PROGRAM_SECID_CMD 8'ha6
`define FPH_OPC_LOCKOUT_SECID_CMD 8'h86
`define FPH_OPC_QEN 8'h3a
`define FPH_OPC_QEX 8'hfe
`define FPH_OPC_ERS 8'h21
`define FPH_OPC_ER32 8'h53
`define FPH_OPC_ER64 8'hd9
`define FPH_OPC_ERSID 8'h9a

// ==========================================================
// Status bits
`define FPH_ST_BUSY 0
`define FPH_ST_WEL 1
`define FPH_ST_BP0 2
`define FPH_ST_BP3 5
`define FPH_ST_LOCK 7
`define FPH_BP_RESET 4'h7

// ==========================================================
// Configuration bits
`define FPH_CF_IOC 1
`define FPH_CF_SEC 3
`define FPH_CF_VLP 4
`define FPH_CF_PROTECT_PIN_ENABLE 7

// ==========================================================
// Security-ID space and erase granules, in bytes
`define FPH_SID_BYTES 2048
`define FPH_SID_FACTORY_BYTES 16
`define FPH_SECTOR_MASK 24'hfff000
`define FPH_BLK32_MASK 24'hff8000
`define FPH_BLK64_MASK 24'hff0000

`endif

// *** logic/fph_pkg.sv ***
// Types for the flash protection, security-ID and pause controller
package fph_pkg;
  typedef enum logic [3:0] {
    FPH_OP_NONE = 4'h0,
    FPH_OP_WRITE_ENABLE_CMD = 4'h1,
    FPH_OP_WRDI = 4'h2,
    FPH_OP_WRITE_STATUS_CMD = 4'h3,
    FPH_OP_RDSR = 4'h4,
    FPH_OP_LOCKDOWN_PROTECT_CMD = 4'h5,
    FPH_OP_PROGRAM_SECID_CMD = 4'h6,
    FPH_OP_LOCKOUT_SECID_CMD = 4'h7,
    FPH_OP_QEN = 4'h8,
    FPH_OP_QEX = 4'h9,
    FPH_OP_ERS = 4'ha,
    FPH_OP_ER32 = 4'hb,
    FPH_OP_ER64 = 4'hc,
    FPH_OP_ERSID = 4'hd
  } fph_op_t;

  typedef enum logic [1:0] {
    FPH_ER_SECTOR = 2'b00,
    FPH_ER_BLK32 = 2'b01,
    FPH_ER_BLK64 = 2'b10
  } fph_erase_t;
endpackage

// *** logic/fph_ctrl.sv ***
// Protocol mode, write protection, security-ID and pause control
`include "fph_params.svh"

// ==========================================================
// Overview of operation
// - Reset starts single-wire; command enters quad mode
// - Quad mode carries everything on four lines
// - Clock modes 0 and 3 both accepted
// - Sample rising edge, drive after falling edge
// - Reset leaves the array write-protected
// - Lock-down needs prior write enable, freezes protection
// - Volatile lock clears only by reset; readable
// - Protect pin only acts outside quad config
// - Protect-pin enable nonvolatile, factory zero
// - Pin guards lock bit, config; not writes
// - Pin high disables the lock bit
// - Unlocked pin-low table for status, config writes
// - Volatile lock refuses protection bit changes
// - Two-Kbyte ID space, 128-bit factory segment
// - ID program writes user part; lockout stops
// - Factory segment and ID erase refused
// - Pause pin alive after power-up, not quad
// - Pause starts at clock-low with select low
// - Pause ends at clock-low after pin rises
// - Paused: output floats, inputs ignored, position kept
// - Select high while paused resets interface
// - Erase decode: 4K sectors, 32K, 64K blocks
// - Hardware reset sets protection, clears lock bit
// - Lock bit 7 makes protection bits read-only while the pin guards
module fph_ctrl
  import fph_pkg::*;
#(
  parameter int WRITE_CYC = `FPH_WRITE_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] quad_io_lines_in,
  output logic [3:0] quad_io_lines_out,
  output logic [3:0] quad_io_lines_oe,
  input wire logic wp_n,
  input wire logic hold_n,
  input wire logic protect_pin_enable_stored,
  input wire logic secid_lock_stored,
  output logic [7:0] status_reg_out,
  output logic [7:0] config_reg_out,
  output logic quad_mode_out,
  output logic busy,
  output logic erase_go,
  output logic [23:0] erase_addr,
  output fph_erase_t erase_kind,
  output logic secid_prog_go,
  output logic [10:0] secid_prog_addr,
  output logic [7:0] secid_prog_data
);

  // ==========================================================
  // Command decode
  function automatic fph_op_t fph_decode(input logic [7:0] opc);
    fph_op_t op;
    op = FPH_OP_NONE;
    if (opc == `FPH_OPC_WRITE_ENABLE_CMD) op = FPH_OP_WRITE_ENABLE_CMD;
    else if (opc == `FPH_OPC_WRDI) op = FPH_OP_WRDI;
    else if (opc == `FPH_OPC_WRITE_STATUS_CMD) op = FPH_OP_WRITE_STATUS_CMD;
    else if (opc == `FPH_OPC_RDSR) op = FPH_OP_RDSR;
    else if (opc == `FPH_OPC_LOCKDOWN_PROTECT_CMD) op = FPH_OP_LOCKDOWN_PROTECT_CMD;
    else if (opc == `FPH_OPC_PROGRAM_SECID_CMD) op = FPH_OP_PROGRAM_SECID_CMD;
    else if (opc == `FPH_OPC_LOCKOUT_SECID_CMD) op = FPH_OP_LOCKOUT_SECID_CMD;
    else if (opc == `FPH_OPC_QEN) op = FPH_OP_QEN;
    else if (opc == `FPH_OPC_QEX) op = FPH_OP_QEX;
    else if (opc == `FPH_OPC_ERS) op = FPH_OP_ERS;
    else if (opc == `FPH_OPC_ER32) op = FPH_OP_ER32;
    else if (opc == `FPH_OPC_ER64) op = FPH_OP_ER64;
    else if (opc == `FPH_OPC_ERSID) op = FPH_OP_ERSID;
    return op;
  endfunction

  // Total bits in a frame, opcode included
  function automatic logic [5:0] fph_len(input fph_op_t op);
    logic [5:0] n;
    n = 6'd8;
    case (op)
      FPH_OP_WRITE_STATUS_CMD: n = 6'd24;
      FPH_OP_PROGRAM_SECID_CMD: n = 6'd40;
      FPH_OP_ERS, FPH_OP_ER32, FPH_OP_ER64, FPH_OP_ERSID: n = 6'd32;
      default: n = 6'd8;
    endcase
    return n;
  endfunction

  // ==========================================================
  // Link side, clocked by sck
  logic frame_rst;
  logic quad_mode_reg;
  logic paused_reg;
  logic [5:0] bit_cnt_reg;
  logic [7:0] opc_reg;
  logic [31:0] data_reg;
  logic done_reg;
  logic rd_active_reg;
  logic [2:0] rd_cnt_reg;
  logic [3:0] dout_reg;
  logic req_tgl_reg;
  fph_op_t req_op_reg;
  logic [31:0] req_data_reg;
  logic [15:0] stat_l1_reg;
  logic [15:0] stat_l2_reg;

  // Select high drops the whole frame, pause included
  assign frame_rst = rst | cs_n;

  wire shifting = !paused_reg && !done_reg;
  wire [5:0] bit_cnt_next = quad_mode_reg ? bit_cnt_reg + 6'd4 : bit_cnt_reg + 6'd1;
  wire [7:0] opc_next = quad_mode_reg ? {opc_reg[3:0], quad_io_lines_in}
                                      : {opc_reg[6:0], quad_io_lines_in[0]};
  wire [31:0] data_next = quad_mode_reg ? {data_reg[27:0], quad_io_lines_in}
                                        : {data_reg[30:0], quad_io_lines_in[0]};
  wire in_opcode = bit_cnt_reg < 6'd8;
  wire fph_op_t op_cur = fph_decode(in_opcode ? opc_next : opc_reg);
  wire cmd_fire = shifting && (bit_cnt_next == fph_len(op_cur));
  wire hold_allowed = !quad_mode_reg;

  // Inputs captured on the rising edge in both clock modes
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_reg <= 6'd0;
      opc_reg <= 8'h00;
      data_reg <= 32'h0;
      done_reg <= 1'b0;
    end else if (shifting) begin
      bit_cnt_reg <= bit_cnt_next;
      if (in_opcode) opc_reg <= opc_next;
      else data_reg <= data_next;
      done_reg <= cmd_fire;
    end
  end

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) rd_active_reg <= 1'b0;
    else if (cmd_fire && op_cur == FPH_OP_RDSR) rd_active_reg <= 1'b1;
  end

  // Mode survives select; only QEX or a hardware or power reset returns to x1
  always_ff @(posedge sck or posedge rst) begin
    if (rst) quad_mode_reg <= 1'b0;
    else if (cmd_fire && op_cur == FPH_OP_QEN) quad_mode_reg <= 1'b1;
    else if (cmd_fire && op_cur == FPH_OP_QEX) quad_mode_reg <= 1'b0;
  end

  // Request words are held until the next completed command other than RDSR, QEN or QEX
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      req_tgl_reg <= 1'b0;
      req_op_reg <= FPH_OP_NONE;
      req_data_reg <= 32'h0;
    end else if (cmd_fire && !in_opcode) begin
      req_tgl_reg <= !req_tgl_reg;
      req_op_reg <= op_cur;
      req_data_reg <= data_next;
    end else if (cmd_fire && op_cur != FPH_OP_RDSR && op_cur != FPH_OP_QEN
                 && op_cur != FPH_OP_QEX) begin
      req_tgl_reg <= !req_tgl_reg;
      req_op_reg <= op_cur;
      req_data_reg <= 32'h0;
    end
  end

  // Pause is taken only while sck is low
  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) paused_reg <= 1'b0;
    else paused_reg <= !hold_n && hold_allowed;
  end

  // Status byte crosses as a quasi-static level; it moves only on commands and write cycles
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      stat_l1_reg <= 16'h0;
      stat_l2_reg <= 16'h0;
    end else begin
      stat_l1_reg <= {status_reg_out, config_reg_out};
      stat_l2_reg <= stat_l1_reg;
    end
  end

  wire [7:0] rd_byte = stat_l2_reg[15:8];
  wire [3:0] rd_nib = rd_cnt_reg[0] ? rd_byte[3:0] : rd_byte[7:4];
  wire [3:0] rd_bit = {2'b00, rd_byte[3'd7 - rd_cnt_reg], 1'b0};

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      rd_cnt_reg <= 3'd0;
      dout_reg <= 4'h0;
    end else if (rd_active_reg && hold_n) begin
      rd_cnt_reg <= rd_cnt_reg + 3'd1;
      dout_reg <= quad_mode_reg ? rd_nib : rd_bit;
    end
  end

  wire drive_out = rd_active_reg && !paused_reg;
  assign quad_io_lines_out = dout_reg;
  assign quad_io_lines_oe = !drive_out ? 4'h0 : (quad_mode_reg ? 4'hf : 4'h2);

  // ==========================================================
  // Register side, clocked by clock
  logic [2:0] req_sync_reg;
  logic [2:0] wp_sync_reg;
  logic [2:0] quad_sync_reg;
  logic wp_lvl_reg;
  logic quad_lvl_reg;
  logic [3:0] bp_reg;
  logic lock_bit_reg;
  logic wel_reg;
  logic ioc_reg;
  logic vlp_reg;
  logic protect_pin_enable_reg;
  logic sid_lock_reg;
  logic loaded_reg;
  logic [$clog2(WRITE_CYC + 1) - 1:0] busy_cnt_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_sync_reg <= 3'b000;
      wp_sync_reg <= 3'b111;
      quad_sync_reg <= 3'b000;
      wp_lvl_reg <= 1'b1;
      quad_lvl_reg <= 1'b0;
    end else begin
      req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
      wp_sync_reg <= {wp_sync_reg[1:0], wp_n};
      quad_sync_reg <= {quad_sync_reg[1:0], quad_mode_reg};
      if (wp_sync_reg[1] == wp_sync_reg[2]) wp_lvl_reg <= wp_sync_reg[2];
      if (quad_sync_reg[1] == quad_sync_reg[2]) quad_lvl_reg <= quad_sync_reg[2];
    end
  end

  wire req_evt = req_sync_reg[1] ^ req_sync_reg[2];
  wire accept = req_evt && !busy;
  wire [23:0] addr = req_op_reg == FPH_OP_PROGRAM_SECID_CMD ? req_data_reg[31:8] : req_data_reg[23:0];

  // Pin counts only when low, enabled, and outside quad config
  wire pin_guard = !wp_lvl_reg && !ioc_reg && !quad_lvl_reg && protect_pin_enable_reg;
  wire bp_allowed = !vlp_reg && !(pin_guard && lock_bit_reg);
  wire cfg_allowed = !pin_guard;
  wire st_ok = accept && req_op_reg == FPH_OP_WRITE_STATUS_CMD && wel_reg && bp_allowed;
  wire cf_ok = accept && req_op_reg == FPH_OP_WRITE_STATUS_CMD && wel_reg && cfg_allowed;
  wire ld_ok = accept && req_op_reg == FPH_OP_LOCKDOWN_PROTECT_CMD && wel_reg;
  wire sid_user = addr >= 24'(`FPH_SID_FACTORY_BYTES) && addr < 24'(`FPH_SID_BYTES);
  wire ps_ok = accept && req_op_reg == FPH_OP_PROGRAM_SECID_CMD && wel_reg && !sid_lock_reg
               && sid_user;
  wire ls_ok = accept && req_op_reg == FPH_OP_LOCKOUT_SECID_CMD && wel_reg && !sid_lock_reg;
  wire er_op = req_op_reg == FPH_OP_ERS || req_op_reg == FPH_OP_ER32
               || req_op_reg == FPH_OP_ER64;
  wire er_ok = accept && er_op && wel_reg;
  wire start_write = st_ok || cf_ok || ps_ok || ls_ok || er_ok;
  wire wel_clear = start_write || ld_ok || (accept && req_op_reg == FPH_OP_WRDI);
  wire [23:0] er_mask = req_op_reg == FPH_OP_ERS ? `FPH_SECTOR_MASK
                      : (req_op_reg == FPH_OP_ER32 ? `FPH_BLK32_MASK : `FPH_BLK64_MASK);

  // Protected array and cleared lock bit straight out of reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bp_reg <= `FPH_BP_RESET;
      lock_bit_reg <= 1'b0;
    end else if (st_ok) begin
      bp_reg <= req_data_reg[8 + `FPH_ST_BP3:8 + `FPH_ST_BP0];
      lock_bit_reg <= req_data_reg[8 + `FPH_ST_LOCK];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) wel_reg <= 1'b0;
    else if (accept && req_op_reg == FPH_OP_WRITE_ENABLE_CMD) wel_reg <= 1'b1;
    else if (wel_clear) wel_reg <= 1'b0;
  end

  // Volatile lock has no clear path but reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) vlp_reg <= 1'b0;
    else if (ld_ok) vlp_reg <= 1'b1;
  end

  // Nonvolatile bits are reloaded from their stored copies after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loaded_reg <= 1'b0;
      protect_pin_enable_reg <= 1'b0;
      sid_lock_reg <= 1'b0;
      ioc_reg <= 1'b0;
    end else if (!loaded_reg) begin
      loaded_reg <= 1'b1;
      protect_pin_enable_reg <= protect_pin_enable_stored;
      sid_lock_reg <= secid_lock_stored;
    end else begin
      if (cf_ok) begin
        ioc_reg <= req_data_reg[`FPH_CF_IOC];
        protect_pin_enable_reg <= req_data_reg[`FPH_CF_PROTECT_PIN_ENABLE];
      end
      if (ls_ok) sid_lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) busy_cnt_reg <= '0;
    else if (start_write) busy_cnt_reg <= ($bits(busy_cnt_reg))'(WRITE_CYC);
    else if (busy_cnt_reg != '0) busy_cnt_reg <= busy_cnt_reg - 1'b1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      erase_go <= 1'b0;
      erase_addr <= 24'h0;
      erase_kind <= FPH_ER_SECTOR;
      secid_prog_go <= 1'b0;
      secid_prog_addr <= 11'h0;
      secid_prog_data <= 8'h00;
    end else begin
      erase_go <= er_ok;
      secid_prog_go <= ps_ok;
      if (er_ok) begin
        erase_addr <= addr & er_mask;
        erase_kind <= req_op_reg == FPH_OP_ERS ? FPH_ER_SECTOR
                    : (req_op_reg == FPH_OP_ER32 ? FPH_ER_BLK32 : FPH_ER_BLK64);
      end
      if (ps_ok) begin
        secid_prog_addr <= addr[10:0];
        secid_prog_data <= req_data_reg[7:0];
      end
    end
  end

  assign busy = busy_cnt_reg != '0;
  assign quad_mode_out = quad_lvl_reg;
  assign status_reg_out = {lock_bit_reg, 1'b0, bp_reg, wel_reg, busy};
  assign config_reg_out = {protect_pin_enable_reg, 2'b00, vlp_reg, sid_lock_reg, 1'b0, ioc_reg, 1'b0};

  // ==========================================================
  // Checks
  sequence s_write_req;
    accept && req_op_reg == FPH_OP_WRITE_STATUS_CMD;
  endsequence

  reset_protect_a: assert property (@(posedge clock) disable iff (rst)
    $past(rst) |-> bp_reg[2:0] == 3'b111 && !lock_bit_reg)
    else $error("protection not set after reset");
  lockdown_wel_a: assert property (@(posedge clock) disable iff (rst)
    $rose(vlp_reg) |-> $past(wel_reg) && !wel_reg)
    else $error("lock-down without write enable");
  vlp_sticky_a: assert property (@(posedge clock) disable iff (rst)
    vlp_reg |=> vlp_reg)
    else $error("volatile lock cleared without reset");
  bp_guard_a: assert property (@(posedge clock) disable iff (rst)
    s_write_req ##0 (vlp_reg || (pin_guard && lock_bit_reg)) |=> $stable(bp_reg))
    else $error("protection bits changed while locked");
  cfg_guard_a: assert property (@(posedge clock) disable iff (rst)
    s_write_req ##0 pin_guard |=> $stable(protect_pin_enable_reg) && $stable(ioc_reg))
    else $error("config changed while pin guards it");
  quad_pin_a: assert property (@(posedge clock) disable iff (rst)
    s_write_req ##0 wel_reg && (quad_lvl_reg || ioc_reg) |=> busy)
    else $error("protect pin active in quad config");
  refuse_idle_a: assert property (@(posedge clock) disable iff (rst)
    $rose(busy) |-> $past(accept) && $past(req_op_reg) != FPH_OP_ERSID)
    else $error("busy without accepted write");
  busy_len_a: assert property (@(posedge clock) disable iff (rst)
    $rose(busy) |-> busy [*8])
    else $error("write cycle cut short");
  sid_lock_a: assert property (@(posedge clock) disable iff (rst)
    secid_prog_go |-> !$past(sid_lock_reg) && secid_prog_addr >= 11'h010)
    else $error("security-ID write refused case let through");
  pause_float_a: assert property (@(posedge sck) disable iff (frame_rst)
    paused_reg |-> quad_io_lines_oe == 4'h0 ##1 $stable(bit_cnt_reg))
    else $error("paused link still active");

endmodule

// *** tb/fph_host_model.sv ***
// Bus host model driving the flash pins in clock mode 0 or 3
`include "fph_params.svh"

module fph_host_model (
  output logic sck,
  output logic cs_n,
  output logic hold_n,
  output logic [3:0] drv,
  input wire logic [3:0] line
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] RD_OP = `FPH_OPC_RDSR;

  // Idle level of the clock between frames: 0 for mode 0, 1 for mode 3
  logic park;

  initial begin
    park = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    drv = 4'h5;
  end

  // Data moves only while the clock is low, so each rising edge finds it settled
  task automatic tick(input logic [3:0] d, input logic h);
    drv = d;
    #15 sck = 1'b1;
    hold_n = h;
    #15 sck = 1'b0;
  endtask

  // Released lines show the inverse of the last value, never a stale copy
  task automatic close_frame();
    #15 cs_n = 1'b1;
    drv = ~drv;
    sck = park;
    #300;
  endtask

  // A pause after bit hold_at: four ticks of junk that a paused device ignores
  task automatic frame(input logic [39:0] d, input int nb, input logic q, input int hold_at);
    int n;
    logic [3:0] v;
    n = q ? nb * 2 : nb * 8;
    cs_n = 1'b0;
    #15 sck = 1'b0;
    for (int i = 0; i < n; i++) begin
      v = q ? d[39 - 4 * i -: 4] : {~drv[3:1], d[39 - i]};
      tick(v, i != hold_at);
      if (i == hold_at) begin
        repeat (3) tick(~v, 1'b0);
        tick(~v, 1'b1);
      end
    end
    close_frame();
  endtask

  // Quad reads take the high nibble first, single-wire reads take line 1
  task automatic rdsr(input logic q, output logic [7:0] v);
    cs_n = 1'b0;
    #15 sck = 1'b0;
    if (q) begin
      tick(RD_OP[7:4], 1'b1);
      tick(RD_OP[3:0], 1'b1);
    end else begin
      for (int i = 0; i < 8; i++) tick({~drv[3:1], RD_OP[7 - i]}, 1'b1);
    end
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      drv = ~drv;
      #15 sck = 1'b1;
      if (q) v[7 - 4 * i -: 4] = line;
      else v[7 - i] = line[1];
      #15 sck = 1'b0;
    end
    close_frame();
  endtask
endmodule

// *** tb/fph_ctrl_bench.sv ***
// Self-checking bench for the protection, security-ID and pause controller
`include "fph_params.svh"

module fph_ctrl_bench
  import fph_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock, rst, sck, cs_n, hold_n, wp_n, protect_pin_enable_stored, secid_lock_stored, qm;
  logic [3:0] host_drv, io_wire, io_out, io_oe;
  logic [7:0] status, cfg, sdata, rd;
  logic quad, busy, erase_go, sgo;
  logic [23:0] erase_addr, ea_cap;
  logic [10:0] saddr, sa_cap;
  logic [7:0] sd_cap;
  fph_erase_t erase_kind, ek_cap;
  int num_errors = 0;
  int cmp_count = 0;
  int erase_seen = 0;
  int sid_seen = 0;
  logic [7:0] ops [3] = '{`FPH_OPC_ERS, `FPH_OPC_ER32, `FPH_OPC_ER64};
  logic [23:0] bases [3] = '{24'h01a000, 24'h018000, 24'h010000};
  fph_erase_t kinds [3] = '{FPH_ER_SECTOR, FPH_ER_BLK32, FPH_ER_BLK64};

  // The wire is the device while it drives, the host otherwise
  assign io_wire = (io_oe & io_out) | (~io_oe & host_drv);

  fph_ctrl #(.WRITE_CYC(40)) fph_ctrl_inst (
    .clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .quad_io_lines_in(io_wire),
    .quad_io_lines_out(io_out), .quad_io_lines_oe(io_oe), .wp_n(wp_n), .hold_n(hold_n),
    .protect_pin_enable_stored(protect_pin_enable_stored), .secid_lock_stored(secid_lock_stored),
    .status_reg_out(status), .config_reg_out(cfg), .quad_mode_out(quad), .busy(busy),
    .erase_go(erase_go), .erase_addr(erase_addr), .erase_kind(erase_kind),
    .secid_prog_go(sgo), .secid_prog_addr(saddr), .secid_prog_data(sdata));

  fph_host_model fph_host_model_inst (
    .sck(sck), .cs_n(cs_n), .hold_n(hold_n), .drv(host_drv), .line(io_wire));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    if (erase_go === 1'b1) begin
      erase_seen <= erase_seen + 1;
      ea_cap <= erase_addr;
      ek_cap <= erase_kind;
    end
    if (sgo === 1'b1) begin
      sid_seen <= sid_seen + 1;
      sa_cap <= saddr;
      sd_cap <= sdata;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic do_reset(input logic protect_pin_enable, input logic slock);
    @(posedge clock);
    #1;
    rst = 1'b1;
    protect_pin_enable_stored = protect_pin_enable;
    secid_lock_stored = slock;
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    repeat (6) @(posedge clock);
    #1;
  endtask

  // Frames are spaced well past the minimum gap by the host's idle time
  task automatic cmd(input logic [39:0] d, input int nb, input int h);
    fph_host_model_inst.frame(d, nb, qm, h);
    repeat (8) @(posedge clock);
    #1;
  endtask

  task automatic write_enable_cmd();
    cmd({`FPH_OPC_WRITE_ENABLE_CMD, 32'h0}, 1, -1);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    #1;
    if (n >= 200) begin
      num_errors++;
      $display("MISMATCH t=%0t busy never cleared", $time);
      conclude();
    end
  endtask

  initial begin
    rst = 1'b1;
    wp_n = 1'b0;
    qm = 1'b0;
    protect_pin_enable_stored = 1'b0;
    secid_lock_stored = 1'b0;
    do_reset(1'b0, 1'b0);
    check(status, 8'h1c);
    check(cfg, 8'h00);
    check({quad, io_oe}, 5'h00);
    fph_host_model_inst.rdsr(1'b0, rd);
    check(rd, 8'h1c);
    cmd({`FPH_OPC_WRITE_STATUS_CMD, 32'h0}, 3, -1);
    check({busy, status}, 9'h01c);
    write_enable_cmd();
    check(status, 8'h1e);
    cmd({`FPH_OPC_WRITE_STATUS_CMD, 32'h0}, 3, -1);
    check(busy, 1'b1);
    wait_idle();
    check(status, 8'h00);
    for (int k = 0; k < 3; k++) begin
      write_enable_cmd();
      cmd({ops[k], 24'h01abcd, 8'h00}, 4, -1);
      wait_idle();
      check(erase_seen, k + 1);
      check({ek_cap, ea_cap}, {kinds[k], bases[k]});
    end
    write_enable_cmd();
    cmd({`FPH_OPC_PROGRAM_SECID_CMD, 24'h000010, 8'h5a}, 5, -1);
    wait_idle();
    check({sid_seen[12:0], sa_cap, sd_cap}, {13'd1, 11'h010, 8'h5a});
    write_enable_cmd();
    cmd({`FPH_OPC_PROGRAM_SECID_CMD, 24'h00000f, 8'h33}, 5, -1);
    check(sid_seen, 1);
    write_enable_cmd();
    cmd({`FPH_OPC_ERSID, 24'h0, 8'h0}, 4, -1);
    check({busy, erase_seen[30:0]}, {1'b0, 31'd3});
    write_enable_cmd();
    cmd({`FPH_OPC_LOCKOUT_SECID_CMD, 32'h0}, 1, -1);
    wait_idle();
    check(cfg[3], 1'b1);
    write_enable_cmd();
    cmd({`FPH_OPC_PROGRAM_SECID_CMD, 24'h000020, 8'h11}, 5, -1);
    check(sid_seen, 1);
    do_reset(1'b1, 1'b1);
    check(cfg, 8'h88);
    write_enable_cmd();
    cmd({`FPH_OPC_WRITE_STATUS_CMD, 8'h80, 8'h00, 16'h0}, 3, -1);
    wait_idle();
    check({status, cfg}, 16'h8088);
    write_enable_cmd();
    cmd({`FPH_OPC_WRITE_STATUS_CMD, 8'h9c, 8'h88, 16'h0}, 3, -1);
    check({busy, status}, 9'h082);
    wp_n = 1'b1;
    write_enable_cmd();
    cmd({`FPH_OPC_WRITE_STATUS_CMD, 8'h9c, 8'h88, 16'h0}, 3, -1);
    wait_idle();
    check(status, 8'h9c);
    cmd({`FPH_OPC_LOCKDOWN_PROTECT_CMD, 32'h0}, 1, -1);
    check(cfg, 8'h88);
    write_enable_cmd();
    cmd({`FPH_OPC_LOCKDOWN_PROTECT_CMD, 32'h0}, 1, -1);
    check(cfg, 8'h98);
    write_enable_cmd();
    cmd({`FPH_OPC_WRITE_STATUS_CMD, 8'h80, 8'h8a, 16'h0}, 3, -1);
    wait_idle();
    check({status, cfg}, 16'h9c9a);
    wp_n = 1'b0;
    write_enable_cmd();
    cmd({`FPH_OPC_WRITE_STATUS_CMD, 8'h80, 8'h88, 16'h0}, 3, -1);
    wait_idle();
    check({status, cfg}, 16'h9c98);
    do_reset(1'b1, 1'b1);
    check({status, cfg}, 16'h1c88);
    cmd({`FPH_OPC_QEN, 32'h0}, 1, -1);
    check(quad, 1'b1);
    qm = 1'b1;
    write_enable_cmd();
    check(status[1], 1'b1);
    fph_host_model_inst.rdsr(1'b1, rd);
    check(rd, 8'h1e);
    cmd({`FPH_OPC_WRDI, 32'h0}, 1, 0);
    check(status[1], 1'b1);
    cmd({`FPH_OPC_QEX, 32'h0}, 1, -1);
    qm = 1'b0;
    check(quad, 1'b0);
    cmd({`FPH_OPC_WRDI, 32'h0}, 1, -1);
    check(status[1], 1'b0);
    cmd({`FPH_OPC_WRITE_ENABLE_CMD, 32'h0}, 1, 3);
    check(status[1], 1'b1);
    fph_host_model_inst.park = 1'b1;
    cmd({`FPH_OPC_WRDI, 32'h0}, 1, -1);
    check(status, 8'h1c);
    fph_host_model_inst.rdsr(1'b0, rd);
    check(rd, 8'h1c);
    cmd({`FPH_OPC_WRITE_ENABLE_CMD, 32'h0}, 1, -1);
    check(status, 8'h1e);
    conclude();
  end

  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    $display("MISMATCH t=%0t run did not finish", $time);
    conclude();
  end
endmodule
